//--- rtl/dpc_pkg.sv
// Purpose: Shared constants and types for the DDR pin command link
// Assumes: x16 organisation, burst of two, link clock = pclk / 8
// Notes: Command codes are {chip select, row, column, write} pin levels
package dpc_pkg;

  // ----------------------------------------------------------------
  // Widths and storage
  // ----------------------------------------------------------------
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 13;
  localparam int COL_W = 3;
  localparam int NUM_BANKS = 4;
  localparam int MEM_WORDS = 64;
  localparam int IDX_W = 6;

  // ----------------------------------------------------------------
  // Command codes and address fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MODE_SET = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESELECT = 4'hF;
  localparam int AUTO_PRE_BIT = 10;
  localparam int EXT_COMP_STROBE_BIT = 10;
  localparam int EXT_READ_ONLY_STROBE_BIT = 11;
  localparam logic [1:0] MODE_SEL_BASE = 2'h0;
  localparam logic [1:0] MODE_SEL_EXT = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;

  // ----------------------------------------------------------------
  // Link clock phases (pclk cycles within one link clock)
  // ----------------------------------------------------------------
  localparam logic [2:0] PH_CLK_FALL = 3'h3;
  localparam logic [2:0] PH_STROBE_RISE = 3'h5;
  localparam logic [2:0] PH_CLK_RISE = 3'h7;
  localparam logic [2:0] PH_STROBE_FALL = 3'h1;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_WMASK = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_CKE_BIT = 0;
  localparam int CTRL_COMP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int CMD_W = 19;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_ADDR_LSB = 6;

  typedef struct packed {
    logic cke;
    logic [1:0] clk;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [1:0] mask;
    logic [1:0] strobe;
    logic [DQ_W-1:0] dq;
  } dpc_pins_type;

  typedef struct packed {
    logic [1:0] strobe;
    logic [DQ_W-1:0] dq;
  } dpc_rd_type;

  function automatic logic [3:0] dpc_decode(input logic [3:0] pins);
    return pins[3] ? CMD_NOP : pins;
  endfunction

  function automatic logic [IDX_W-1:0] dpc_index(input logic [1:0] bank,
                                                 input logic row_lsb,
                                                 input logic [COL_W-1:0] col);
    return {bank, row_lsb, col};
  endfunction

endpackage

//--- rtl/dpc_link_if.sv
// Purpose: Pin bundle between the memory device and its controller
// Assumes: Each two-way pin has a value and an active-low enable per end
// Notes: Undriven data and true strobes resolve to zero, complement strobes to one
`timescale 1ns/1ps
`default_nettype none
interface dpc_link_if
  import dpc_pkg::*;
();
  logic [1:0] diff_clk_pair;
  logic clk_gate;
  logic chip_sel_n;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_en_n;
  logic bank_sel_bit0;
  logic bank_sel_bit1;
  logic [ADDR_W-1:0] addr;
  logic lower_lane_mask;
  logic upper_lane_mask;
  logic [DQ_W-1:0] ctl_dq_out;
  logic [DQ_W-1:0] dev_dq_out;
  logic ctl_dq_oe_n;
  logic dev_dq_oe_n;
  logic [1:0] ctl_strobe_out;
  logic [1:0] dev_strobe_out;
  logic ctl_strobe_oe_n;
  logic dev_strobe_oe_n;
  logic ctl_strobe_c_oe_n;
  logic dev_strobe_c_oe_n;
  logic [DQ_W-1:0] dq;
  logic [1:0] strobe;
  logic lower_lane_strobe;
  logic upper_lane_strobe;
  logic lower_lane_strobe_c;
  logic upper_lane_strobe_c;

  assign dq = !dev_dq_oe_n ? dev_dq_out : (!ctl_dq_oe_n ? ctl_dq_out : '0);
  assign strobe = !dev_strobe_oe_n ? dev_strobe_out :
                  (!ctl_strobe_oe_n ? ctl_strobe_out : 2'h0);
  assign lower_lane_strobe = strobe[0];
  assign upper_lane_strobe = strobe[1];
  assign lower_lane_strobe_c = !dev_strobe_c_oe_n ? ~dev_strobe_out[0] :
                               (!ctl_strobe_c_oe_n ? ~ctl_strobe_out[0] : 1'b1);
  assign upper_lane_strobe_c = !dev_strobe_c_oe_n ? ~dev_strobe_out[1] :
                               (!ctl_strobe_c_oe_n ? ~ctl_strobe_out[1] : 1'b1);

  modport device(
    input diff_clk_pair, clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n,
    input bank_sel_bit0, bank_sel_bit1, addr, lower_lane_mask, upper_lane_mask, dq, strobe,
    output dev_dq_out, dev_dq_oe_n, dev_strobe_out, dev_strobe_oe_n, dev_strobe_c_oe_n
  );

  modport controller(
    output diff_clk_pair, clk_gate, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n,
    output bank_sel_bit0, bank_sel_bit1, addr, lower_lane_mask, upper_lane_mask,
    output ctl_dq_out, ctl_dq_oe_n, ctl_strobe_out, ctl_strobe_oe_n, ctl_strobe_c_oe_n,
    input dq, strobe
  );
endinterface
`default_nettype wire

//--- rtl/dpc_device.sv
// Purpose: Pin-level model of a four-bank DDR memory device
// Assumes: All link pins arrive asynchronously and are filtered on pclk
// Notes: Small array indexed by bank, row bit 0 and column
//
// Summary of operation
// R1 - Commands registered at rising clock crossing only
// R2 - Read beats leave on both clock crossings
// R3 - Clock gate low disables buffers and drivers
// R4 - Gate low: idle gives precharge, open gives active
// R5 - Gate sampled on edges; self refresh exit asynchronous
// R6 - Controller keeps clock gate high during accesses
// R7 - Power-down ignores all but clock and gate
// R8 - Chip select high masks any command
// R9 - Command decoded from four strobes together
// R10 - Masked write beats are not stored
// R11 - Mask captured on both strobe edges
// R12 - Each lane mask gates its own lane
// R13 - x8 read-only strobe option disables masking
// R14 - Bank bits pick the addressed bank
// R15 - Bank bits pick base or extended mode
// R16 - Bank zero mode set writes base mode
// R17 - Address carries row, column, auto precharge
// R18 - Address bit ten chooses one or all banks
// R19 - Mode set stores address as operation code
// R20 - Read strobe edge aligned; write strobe centered
// R21 - Each lane strobe times its own byte
// R22 - Extended bit enables complementary strobes
// R23 - Data and strobes float until a read
`timescale 1ns/1ps
`default_nettype none
module dpc_device
  import dpc_pkg::*;
#(
  parameter bit ORG_X8 = 1'b0
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link pins
  dpc_link_if.device link,
  // Device state
  output logic [ADDR_W-1:0] base_mode,
  output logic [ADDR_W-1:0] ext_mode,
  output logic [NUM_BANKS-1:0] rows_open,
  output logic power_down,
  output logic active_power_down,
  output logic self_refresh
);

  typedef enum logic [2:0]
  {
    PWR_RUN = 3'b001,
    PWR_DOWN = 3'b010,
    PWR_SELF = 3'b100
  } dpc_pwr_type;

  dpc_pwr_type pwr;
  dpc_pins_type pins_raw;
  dpc_pins_type s1;
  dpc_pins_type s2;
  dpc_pins_type s3;
  dpc_pins_type filt;
  dpc_pins_type prev;
  logic [DQ_W-1:0] mem [MEM_WORDS];
  logic [NUM_BANKS-1:0] row_lsb;
  logic [IDX_W-1:0] acc_idx;
  logic [1:0] acc_bank;
  logic ap_flag;
  logic rd_drive;
  logic rd_beat;
  logic [DQ_W-1:0] dq_out;
  logic [1:0] strobe_out;
  logic [1:0] wr_left;
  logic clk_rise;
  logic clk_fall;
  logic [1:0] strb_rise;
  logic [1:0] strb_fall;
  logic cmd_take;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [IDX_W-1:0] idx_now;
  logic rd_end;
  logic wr_end;
  logic mask_en;
  logic running;

  // ----------------------------------------------------------------
  // Pin filter
  // ----------------------------------------------------------------
  assign pins_raw = {link.clk_gate, link.diff_clk_pair,
                     link.chip_sel_n, link.row_strobe_n, link.col_strobe_n, link.write_en_n,
                     link.bank_sel_bit1, link.bank_sel_bit0, link.addr,
                     link.upper_lane_mask, link.lower_lane_mask, link.strobe, link.dq};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      prev <= '0;
    end
    else
    begin
      s1 <= pins_raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
      prev <= filt;
    end
  end

  // Rising crossing: true high and complement low, newly
  assign clk_rise = filt.clk[0] & ~filt.clk[1] & ~(prev.clk[0] & ~prev.clk[1]); // R1
  assign clk_fall = ~filt.clk[0] & filt.clk[1] & ~(~prev.clk[0] & prev.clk[1]); // R2
  assign strb_rise = filt.strobe & ~prev.strobe;
  assign strb_fall = ~filt.strobe & prev.strobe;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign running = (pwr == PWR_RUN);
  assign cmd_take = clk_rise & running & filt.cke; // R3 R7
  assign cmd = dpc_decode(filt.cmd); // R8 R9
  assign bank = filt.ba; // R14
  assign idx_now = dpc_index(bank, row_lsb[bank], filt.addr[COL_W-1:0]); // R17
  assign rd_end = rd_drive & rd_beat & clk_rise;
  assign wr_end = (wr_left != 2'h0) && ((wr_left & ~strb_fall) == 2'h0);

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr <= PWR_RUN;
      active_power_down <= 1'b0;
    end
    else
    begin
      unique case (pwr)
        PWR_RUN:
          if (clk_rise & ~filt.cke) // R5
          begin
            if (cmd == CMD_REFRESH && rows_open == '0) // R4
              pwr <= PWR_SELF;
            else
              pwr <= PWR_DOWN;
            active_power_down <= |rows_open; // R4
          end
        PWR_DOWN:
          if (clk_rise & filt.cke) // R5
          begin
            pwr <= PWR_RUN;
            active_power_down <= 1'b0;
          end
        PWR_SELF:
          if (filt.cke) // R5 R7
            pwr <= PWR_RUN;
      endcase
    end
  end

  assign power_down = (pwr == PWR_DOWN);
  assign self_refresh = (pwr == PWR_SELF);

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_mode <= MODE_RESET;
      ext_mode <= MODE_RESET;
    end
    else if (cmd_take && cmd == CMD_MODE_SET)
    begin
      if (bank == MODE_SEL_BASE) // R15 R16
        base_mode <= filt.addr; // R19
      else if (bank == MODE_SEL_EXT) // R15
        ext_mode <= filt.addr; // R19
    end
  end

  // ----------------------------------------------------------------
  // Bank rows
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rows_open <= '0;
      row_lsb <= '0;
    end
    else
    begin
      if (cmd_take && cmd == CMD_ACTIVE)
      begin
        rows_open[bank] <= 1'b1; // R14
        row_lsb[bank] <= filt.addr[0]; // R17
      end
      else if (cmd_take && cmd == CMD_PRECHARGE)
      begin
        if (filt.addr[AUTO_PRE_BIT])
          rows_open <= '0; // R18
        else
          rows_open[bank] <= 1'b0; // R18
      end
      if ((rd_end | wr_end) & ap_flag)
        rows_open[acc_bank] <= 1'b0; // R17
    end
  end

  // ----------------------------------------------------------------
  // Access tracking
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_idx <= '0;
      acc_bank <= 2'h0;
      ap_flag <= 1'b0;
    end
    else if (cmd_take && (cmd == CMD_READ || cmd == CMD_WRITE))
    begin
      acc_idx <= idx_now; // R14
      acc_bank <= bank;
      ap_flag <= filt.addr[AUTO_PRE_BIT]; // R17
    end
  end

  // ----------------------------------------------------------------
  // Read drive
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_drive <= 1'b0;
      rd_beat <= 1'b0;
      dq_out <= '0;
      strobe_out <= 2'h0;
    end
    else if (cmd_take && cmd == CMD_READ)
    begin
      rd_drive <= 1'b1;
      rd_beat <= 1'b0;
      dq_out <= mem[idx_now];
      strobe_out <= 2'h3; // R20
    end
    else if (rd_drive && !rd_beat && clk_fall)
    begin
      dq_out <= mem[acc_idx ^ 6'h01]; // R2
      strobe_out <= 2'h0; // R20
      rd_beat <= 1'b1;
    end
    else if (rd_end)
      rd_drive <= 1'b0;
  end

  assign link.dev_dq_out = dq_out;
  assign link.dev_strobe_out = strobe_out; // R21
  assign link.dev_dq_oe_n = ~(rd_drive & running); // R3 R23
  assign link.dev_strobe_oe_n = ~(rd_drive & running); // R3 R23
  assign link.dev_strobe_c_oe_n = ~(rd_drive & running & ext_mode[EXT_COMP_STROBE_BIT]); // R22

  // ----------------------------------------------------------------
  // Write capture
  // ----------------------------------------------------------------
  assign mask_en = ~(ORG_X8 & ext_mode[EXT_READ_ONLY_STROBE_BIT]); // R13

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wr_left <= 2'h0;
    else if (cmd_take && cmd == CMD_WRITE)
      wr_left <= 2'h3;
    else
      wr_left <= wr_left & ~strb_fall;
  end

  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      // Lane strobe edges sample the lane data and its mask together
      if (running && wr_left[i] && !(mask_en && filt.mask[ORG_X8 ? 0 : i])) // R10 R11 R12
      begin
        if (strb_rise[i]) // R21
          mem[acc_idx][i*LANE_W +: LANE_W] <= filt.dq[i*LANE_W +: LANE_W];
        if (strb_fall[i]) // R11 R21
          mem[acc_idx ^ 6'h01][i*LANE_W +: LANE_W] <= filt.dq[i*LANE_W +: LANE_W];
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/dpc_controller.sv
// Purpose: Controller end of the DDR pin link, ordered over APB
// Assumes: Link clock is pclk / 8 driven out by this end
// Notes: One command at a time; busy refuses new commands
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dpc_controller
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link pins
  dpc_link_if.controller link
);

  typedef enum logic [3:0]
  {
    C_IDLE = 4'b0001,
    C_CMD = 4'b0010,
    C_WR = 4'b0100,
    C_RD = 4'b1000
  } dpc_ctl_type;

  dpc_ctl_type state;
  logic [2:0] phase;
  logic clk_t;
  logic [1:0] ctrl;
  logic [CMD_W-1:0] cmd_reg;
  logic [31:0] wdata;
  logic [3:0] wmask;
  logic [31:0] rdata;
  logic pending;
  logic [CMD_W-1:0] pins_cmd;
  logic cke;
  logic dq_drive;
  logic [DQ_W-1:0] dq_out;
  logic [1:0] strobe_out;
  logic [1:0] mask_out;
  dpc_rd_type s1;
  dpc_rd_type s2;
  dpc_rd_type s3;
  dpc_rd_type filt;
  dpc_rd_type prev;
  logic at_fall;
  logic busy;
  logic is_wr;
  logic is_rd;
  logic mapped;
  logic apb_wr;

  assign at_fall = (phase == PH_CLK_FALL);
  assign busy = pending | (state != C_IDLE);
  assign is_wr = (dpc_decode(cmd_reg[3:0]) == CMD_WRITE);
  assign is_rd = (dpc_decode(cmd_reg[3:0]) == CMD_READ);

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  assign apb_wr = psel & penable & pwrite;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_WDATA) ||
                  (paddr == REG_WMASK) || (paddr == REG_RDATA) || (paddr == REG_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RESET;
      cmd_reg <= {13'h0000, 2'h0, CMD_DESELECT};
      wdata <= 32'h00000000;
      wmask <= 4'h0;
      pending <= 1'b0;
    end
    else
    begin
      if (state == C_IDLE && pending && at_fall)
        pending <= 1'b0;
      if (apb_wr && paddr == REG_CTRL)
        ctrl <= pwdata[1:0];
      if (apb_wr && paddr == REG_CMD && !busy)
      begin
        cmd_reg <= pwdata[CMD_W-1:0];
        pending <= 1'b1;
      end
      if (apb_wr && paddr == REG_WDATA && !busy)
        wdata <= pwdata;
      if (apb_wr && paddr == REG_WMASK && !busy)
        wmask <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
    begin
      unique case (paddr)
        REG_CTRL: prdata <= {30'h00000000, ctrl};
        REG_CMD: prdata <= {13'h0000, cmd_reg};
        REG_WDATA: prdata <= wdata;
        REG_WMASK: prdata <= {28'h0000000, wmask};
        REG_RDATA: prdata <= rdata;
        REG_STATUS: prdata <= {30'h00000000, cke, busy};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 3'h0;
      clk_t <= 1'b1;
    end
    else
    begin
      phase <= phase + 3'h1;
      if (phase == PH_CLK_RISE)
        clk_t <= 1'b1;
      else if (at_fall)
        clk_t <= 1'b0;
    end
  end

  assign link.diff_clk_pair = {~clk_t, clk_t};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= C_IDLE;
    else
    begin
      unique case (state)
        C_IDLE: if (at_fall && pending) state <= C_CMD;
        C_CMD: if (at_fall) state <= is_wr ? C_WR : (is_rd ? C_RD : C_IDLE);
        C_WR: if (at_fall) state <= C_IDLE;
        C_RD: if (|(~filt.strobe & prev.strobe)) state <= C_IDLE;
      endcase
    end
  end

  // Command pins change on the falling clock so they stand at the rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_cmd <= {13'h0000, 2'h0, CMD_DESELECT};
      cke <= CTRL_RESET[CTRL_CKE_BIT];
    end
    else if (at_fall)
    begin
      if (state == C_IDLE && pending)
        pins_cmd <= cmd_reg; // R1 R9
      else
        pins_cmd <= {pins_cmd[CMD_W-1:4], CMD_DESELECT}; // R8
      cke <= ctrl[CTRL_CKE_BIT] | (busy & (is_wr | is_rd)); // R6
    end
  end

  assign link.chip_sel_n = pins_cmd[3];
  assign link.row_strobe_n = pins_cmd[2];
  assign link.col_strobe_n = pins_cmd[1];
  assign link.write_en_n = pins_cmd[0];
  assign link.bank_sel_bit0 = pins_cmd[CMD_BANK_LSB]; // R14
  assign link.bank_sel_bit1 = pins_cmd[CMD_BANK_LSB+1];
  assign link.addr = pins_cmd[CMD_ADDR_LSB +: ADDR_W]; // R17 R19
  assign link.clk_gate = cke;

  // ----------------------------------------------------------------
  // Write data, centered strobe
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_drive <= 1'b0;
      dq_out <= '0;
      strobe_out <= 2'h0;
      mask_out <= 2'h0;
    end
    else if (state == C_CMD && at_fall && is_wr)
    begin
      dq_drive <= 1'b1;
      dq_out <= wdata[DQ_W-1:0];
      mask_out <= wmask[1:0]; // R11
      strobe_out <= 2'h0;
    end
    else if (state == C_WR)
    begin
      if (phase == PH_STROBE_RISE)
        strobe_out <= 2'h3; // R20
      if (phase == PH_CLK_RISE)
      begin
        dq_out <= wdata[31:16];
        mask_out <= wmask[3:2]; // R11
      end
      if (phase == PH_STROBE_FALL)
        strobe_out <= 2'h0; // R20
      if (at_fall)
        dq_drive <= 1'b0;
    end
  end

  assign link.ctl_dq_out = dq_out;
  assign link.ctl_dq_oe_n = ~dq_drive;
  assign link.ctl_strobe_out = strobe_out;
  assign link.ctl_strobe_oe_n = ~dq_drive;
  assign link.ctl_strobe_c_oe_n = ~(dq_drive & ctrl[CTRL_COMP_BIT]);
  assign link.lower_lane_mask = mask_out[0];
  assign link.upper_lane_mask = mask_out[1];

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      prev <= '0;
    end
    else
    begin
      s1 <= {link.strobe, link.dq};
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & s3) | (filt & (s2 ^ s3));
      prev <= filt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= 32'h00000000;
    else if (state == C_RD)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (filt.strobe[i] & ~prev.strobe[i])
          rdata[i*LANE_W +: LANE_W] <= filt.dq[i*LANE_W +: LANE_W];
        if (~filt.strobe[i] & prev.strobe[i])
          rdata[DQ_W + i*LANE_W +: LANE_W] <= filt.dq[i*LANE_W +: LANE_W];
      end
    end
  end

endmodule
`default_nettype wire

//--- testbench/dpc_link_chk.sv
// Purpose: Pin checks on the DDR link between both ends
// Assumes: One pclk domain, resolved link signals
// Notes: Bursts are two beats, link clock is eight pclk
`timescale 1ns/1ps
`default_nettype none
module dpc_link_chk
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic [1:0] diff_clk_pair,
  input wire logic clk_gate,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic ctl_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic [1:0] strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd; strobe == 2'h3 ##[3:5] strobe == 2'h0; endsequence
  sequence s_wr; strobe == 2'h0 ##2 strobe == 2'h3; endsequence
  property p_pair; diff_clk_pair[1] == !diff_clk_pair[0]; endproperty
  a_pair: assert property (p_pair) else $error("clock pair");
  property p_cmd; $changed({chip_sel_n, row_strobe_n}) |-> !diff_clk_pair[0]; endproperty
  a_cmd: assert property (p_cmd) else $error("command edge");
  property p_clash; !(!ctl_dq_oe_n && !dev_dq_oe_n); endproperty
  a_clash: assert property (p_clash) else $error("data clash");
  property p_rgate; !dev_dq_oe_n |-> clk_gate; endproperty
  a_rgate: assert property (p_rgate) else $error("gate in read");
  property p_wgate; !ctl_dq_oe_n |-> clk_gate; endproperty
  a_wgate: assert property (p_wgate) else $error("gate in write");
  property p_rd; $fell(dev_dq_oe_n) |-> s_rd; endproperty
  a_rd: assert property (p_rd) else $error("read strobe");
  property p_rlen; $fell(dev_dq_oe_n) |-> !dev_dq_oe_n [*6] ##[1:4] dev_dq_oe_n; endproperty
  a_rlen: assert property (p_rlen) else $error("read length");
  property p_wr; $fell(ctl_dq_oe_n) |-> s_wr; endproperty
  a_wr: assert property (p_wr) else $error("write strobe");
  property p_wlen; $fell(ctl_dq_oe_n) |-> !ctl_dq_oe_n [*7] ##[1:3] ctl_dq_oe_n; endproperty
  a_wlen: assert property (p_wlen) else $error("write length");
endmodule
`default_nettype wire

//--- testbench/ddr_sdram_pin_command_interface_tb_top.sv
// Purpose: Both link ends ordered over APB
// Assumes: x16 device, link clock pclk / 8
// Notes: Byte model of the array checks every read
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_pin_command_interface_tb_top
  import dpc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, r0;
  logic [12:0] base_mode, ext_mode;
  logic [3:0] rows_open;
  logic power_down, active_power_down, self_refresh;
  logic [15:0] mem [int];
  int num_errors = 0, num_checks = 0;
  always #20 pclk = ~pclk;
  dpc_link_if link();
  dpc_controller i_dpc_controller(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link);
  dpc_device i_dpc_device(.pclk, .presetn, .link, .base_mode, .ext_mode, .rows_open,
    .power_down, .active_power_down, .self_refresh);
  dpc_link_chk i_dpc_link_chk(.pclk, .presetn, .diff_clk_pair(link.diff_clk_pair),
    .clk_gate(link.clk_gate), .chip_sel_n(link.chip_sel_n), .row_strobe_n(link.row_strobe_n),
    .ctl_dq_oe_n(link.ctl_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n), .strobe(link.strobe));
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (24) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    int n;
    apb(1'b1, REG_CMD, {13'h0, a, b, c});
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 40);
    check("busy", rd[0], 32'h0);
    settle();
  endtask
  task automatic wr(input logic [1:0] b, input logic [2:0] c, input logic [31:0] d,
                    input logic [3:0] m);
    int i;
    apb(1'b1, REG_WDATA, d);
    apb(1'b1, REG_WMASK, {28'h0, m});
    cmd(CMD_WRITE, b, {10'h0, c});
    for (int j = 0; j < 4; j++)
    begin
      i = b * 16 + r0 * 8 + (c ^ (j >> 1));
      if (!mem.exists(i))
        mem[i] = 16'hXXXX;
      if (!m[j])
        mem[i][8 * (j & 1) +: 8] = d[8 * j +: 8];
    end
  endtask
  initial
  begin
    logic [31:0] d;
    logic [2:0] c;
    void'($urandom(32'h7f9b9e03));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("dq_oe_n", link.dev_dq_oe_n, 32'h1);
    check("modes", {base_mode, ext_mode}, 32'h0);
    d = $urandom & 32'h3FF;
    cmd(CMD_MODE_SET, MODE_SEL_BASE, d[12:0]);
    check("base", base_mode, d);
    cmd(CMD_MODE_SET, MODE_SEL_EXT, ~d[12:0] & 13'h3FF);
    check("ext", ext_mode, ~d & 32'h3FF);
    cmd(4'h8, MODE_SEL_BASE, 13'h0);
    check("base", base_mode, d);
    apb(1'b0, 8'h40, 32'h0);
    check("err", er, 32'h1);
    check("unmapped", rd, 32'h0);
    $display("mode test end");
    for (int b = 0; b < 4; b++)
    begin
      r0 = $urandom;
      c = $urandom;
      cmd(CMD_ACTIVE, b[1:0], {12'h0, r0});
      check("open", rows_open, 32'hF >> (3 - b));
      wr(b[1:0], c, $urandom, 4'h0);
      d = $urandom;
      wr(b[1:0], c, $urandom, d[3:0]);
      cmd(CMD_READ, b[1:0], {10'h0, c ^ 3'h1});
      apb(1'b0, REG_RDATA, 32'h0);
      check("rdata", rd, {mem[b * 16 + r0 * 8 + c], mem[b * 16 + r0 * 8 + (c ^ 1)]});
    end
    $display("data test end");
    apb(1'b1, REG_CTRL, 32'h0);
    settle();
    check("apd", {power_down, active_power_down}, 32'h3);
    apb(1'b1, REG_CTRL, 32'h1);
    settle();
    check("pd", power_down, 32'h0);
    cmd(CMD_PRECHARGE, 2'h1, 13'h0);
    check("open", rows_open, 32'hD);
    cmd(CMD_PRECHARGE, 2'h0, 13'h400);
    check("open", rows_open, 32'h0);
    @(negedge link.diff_clk_pair[0]);
    apb(1'b1, REG_CMD, {28'h0, CMD_REFRESH});
    apb(1'b1, REG_CTRL, 32'h0);
    settle();
    check("sr", self_refresh, 32'h1);
    apb(1'b1, REG_CTRL, 32'h1);
    settle();
    check("sr", {self_refresh, power_down}, 32'h0);
    $display("power test end");
    conclude();
  end
endmodule
`default_nettype wire
